// File: sim/tb_urxtx_top.sv
/*
 * tb_urxtx_top: register-level tests of the serial block against a remote station.
 * Assumes divisor 4 matches the remote's bit time; no other clock.
 */
`timescale 1ns/1ps
module tb_urxtx_top
   import urxtx_pkg::*;
();
   logic           ref_clk = 1'b0; // 100 MHz
   logic           resetn  = 1'b0; // active low
   urxtx_bus_req_t bus_req = '0;   // register master
   logic [7:0]     rd_data_q;
   logic           rxd;
   logic           cts_n   = 1'b1; // held off at first
   logic           txd_q;
   logic           tx_irq_q;
   logic           rx_irq_q;
   int             fails   = 0;
   int             n_tests = 0;
   logic [8:0]     got;
   logic [7:0]     rv;

   always #5 ref_clk = ~ref_clk;

   urxtx_top u_dut (.ref_clk(ref_clk), .resetn(resetn), .bus_req(bus_req),
      .rd_data_q(rd_data_q), .rxd(rxd), .cts_n(cts_n), .txd_q(txd_q),
      .tx_irq_q(tx_irq_q), .rx_irq_q(rx_irq_q));
   urxtx_remote u_remote (.ref_clk(ref_clk), .txd_q(txd_q), .rxd(rxd));

   // single-cycle write strobe
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge ref_clk) bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge ref_clk) bus_req <= '0;
   endtask : wr

   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [11:0] a, output logic [7:0] d);
      @(posedge ref_clk) bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge ref_clk) bus_req <= '0;
      #1 d = rd_data_q;
   endtask : rd

   task automatic chk(input logic [8:0] g, input logic [8:0] e);
      n_tests++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk

   task automatic rchk(input logic [11:0] a, input logic [7:0] e);
      rd(a, rv);
      chk({1'b0, rv}, {1'b0, e});
   endtask : rchk

   // one status bit, the rest depend on transmit state
   task automatic bchk(input logic [11:0] a, input int b, input logic e);
      rd(a, rv);
      chk({8'h00, rv[b]}, {8'h00, e});
   endtask : bchk

   // configuration changes only with the unit switched off
   task automatic cfg(input logic [7:0] c0, input logic [7:0] c1);
      wr(URXTX_CTL0_ADDR, 8'h00);
      wr(URXTX_CTL1_ADDR, c1);
      wr(URXTX_CTL0_ADDR, c0);
   endtask : cfg

   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : wrap_up

   // about 15 frames of 700 clocks are expected; this is a generous margin
   initial begin
      repeat (60000) @(posedge ref_clk);
      fails++;
      wrap_up();
   end

   initial begin
      repeat (16) @(posedge ref_clk);
      resetn <= 1'b1;
      rchk(URXTX_CTL0_ADDR, URXTX_CTL0_RST);
      rchk(URXTX_STAT1_ADDR, 8'h00);
      rchk(12'h000, 8'h00); // unmapped place reads zero
      $display("test reset done");
      // transmit held back by clear-to-send
      wr(URXTX_BRH_ADDR, 8'h00);
      wr(URXTX_BRL_ADDR, 8'h04);
      cfg(8'hE0, 8'h00);
      wr(URXTX_DATA_ADDR, 8'h96);
      repeat (300) @(posedge ref_clk);
      chk({8'h00, txd_q}, 9'h001);
      cts_n <= 1'b0;
      u_remote.recv(1'b0, got);
      chk(got, 9'h096);
      $display("test cts transmit done");
      // nine-bit transmit with address and data markers
      cfg(8'hE0, 8'h31);
      repeat (3) @(posedge ref_clk);
      chk({8'h00, tx_irq_q}, 9'h001);
      wr(URXTX_DATA_ADDR, 8'h5A);
      u_remote.recv(1'b1, got);
      chk(got, 9'h15A);
      cfg(8'hE0, 8'h21);
      wr(URXTX_DATA_ADDR, 8'hA5);
      u_remote.recv(1'b1, got);
      chk(got, 9'h0A5);
      $display("test mp transmit done");
      // plain receive, then with the data request switched off
      cfg(8'hC0, 8'h00);
      u_remote.send(8'h3C, 1'b0, 1'b0, 1'b1);
      chk({8'h00, rx_irq_q}, 9'h001);
      bchk(URXTX_STAT0_ADDR, URXTX_ST0_RX_AVAIL, 1'b1);
      rchk(URXTX_DATA_ADDR, 8'h3C);
      bchk(URXTX_STAT0_ADDR, URXTX_ST0_RX_AVAIL, 1'b0);
      cfg(8'hC0, 8'h02);
      u_remote.send(8'h77, 1'b0, 1'b0, 1'b1);
      chk({8'h00, rx_irq_q}, 9'h000);
      rchk(URXTX_DATA_ADDR, 8'h77);
      $display("test receive done");
      // overrun: second byte arrives unread
      cfg(8'hC0, 8'h00);
      u_remote.send(8'h11, 1'b0, 1'b0, 1'b1);
      u_remote.send(8'h22, 1'b0, 1'b0, 1'b1);
      bchk(URXTX_STAT0_ADDR, URXTX_ST0_OVERRUN, 1'b0);
      rchk(URXTX_DATA_ADDR, 8'h11);
      bchk(URXTX_STAT0_ADDR, URXTX_ST0_OVERRUN, 1'b1);
      bchk(URXTX_STAT0_ADDR, URXTX_ST0_RX_AVAIL, 1'b1);
      rd(URXTX_DATA_ADDR, rv);
      bchk(URXTX_STAT0_ADDR, URXTX_ST0_OVERRUN, 1'b0);
      bchk(URXTX_STAT0_ADDR, URXTX_ST0_RX_AVAIL, 1'b0);
      $display("test overrun done");
      // whole character low, stop included
      u_remote.send(8'h00, 1'b0, 1'b0, 1'b0);
      bchk(URXTX_STAT0_ADDR, URXTX_ST0_BREAK, 1'b1);
      bchk(URXTX_STAT0_ADDR, URXTX_ST0_FRAMING, 1'b1);
      chk({8'h00, rx_irq_q}, 9'h001);
      rd(URXTX_DATA_ADDR, rv);
      bchk(URXTX_STAT0_ADDR, URXTX_ST0_FRAMING, 1'b0);
      $display("test break done");
      // address-only request mode, markers and new frame
      cfg(8'hC0, 8'h60);
      u_remote.send(8'h42, 1'b1, 1'b0, 1'b1);
      chk({8'h00, rx_irq_q}, 9'h000);
      rchk(URXTX_DATA_ADDR, 8'h42);
      u_remote.send(8'h05, 1'b1, 1'b1, 1'b1);
      chk({8'h00, rx_irq_q}, 9'h001);
      bchk(URXTX_STAT1_ADDR, URXTX_ST1_MP_RX, 1'b1);
      rchk(URXTX_DATA_ADDR, 8'h05);
      bchk(URXTX_STAT1_ADDR, URXTX_ST1_MP_RX, 1'b0);
      u_remote.send(8'h33, 1'b1, 1'b0, 1'b1);
      bchk(URXTX_STAT1_ADDR, URXTX_ST1_NEW_FRAME, 1'b1);
      rchk(URXTX_DATA_ADDR, 8'h33);
      bchk(URXTX_STAT1_ADDR, URXTX_ST1_NEW_FRAME, 1'b0);
      $display("test mp receive done");
      // data requests only after our own address
      wr(URXTX_ACMP_ADDR, 8'h05);
      cfg(8'hC0, 8'hA0);
      u_remote.send(8'h05, 1'b1, 1'b1, 1'b1);
      chk({8'h00, rx_irq_q}, 9'h000);
      rchk(URXTX_DATA_ADDR, 8'h05);
      u_remote.send(8'h44, 1'b1, 1'b0, 1'b1);
      chk({8'h00, rx_irq_q}, 9'h001);
      rchk(URXTX_DATA_ADDR, 8'h44);
      $display("test mp match done");
      // even parity with a wrong ninth bit 0 for 01, then parity ignored under mp
      cfg(8'hD0, 8'h00);
      u_remote.send(8'h01, 1'b1, 1'b0, 1'b1);
      bchk(URXTX_STAT0_ADDR, URXTX_ST0_PARITY, 1'b1);
      rchk(URXTX_DATA_ADDR, 8'h01);
      bchk(URXTX_STAT0_ADDR, URXTX_ST0_PARITY, 1'b0);
      cfg(8'hD0, 8'h20);
      u_remote.send(8'h01, 1'b1, 1'b0, 1'b1);
      bchk(URXTX_STAT0_ADDR, URXTX_ST0_PARITY, 1'b0);
      rchk(URXTX_DATA_ADDR, 8'h01);
      $display("test parity done");
      wrap_up();
   end
endmodule : tb_urxtx_top

// File: sim/urxtx_remote.sv
/*
 * urxtx_remote: far serial station; sends frames on rxd, captures frames on txd.
 * Assumes the bench clock and a bit time of BIT_CLKS clocks (divisor 4).
 */
`timescale 1ns/1ps
module urxtx_remote #(
   parameter int BIT_CLKS = 64 // 16 ticks of 4 clocks
) (
   input  wire logic ref_clk,
   input  wire logic txd_q,
   output logic      rxd
);
   // idle line is high between frames
   initial rxd = 1'b1;

   // one frame: start, 8 data lsb first, optional ninth, stop at chosen level
   task automatic send(input logic [7:0] data, input logic has_ninth,
                       input logic ninth, input logic stop_lvl);
      logic [10:0] bits;
      int          n;
      bits = {stop_lvl, ninth, data, 1'b0};
      n = has_ninth ? 11 : 10;
      if (!has_ninth) begin
         bits[9] = stop_lvl;
      end
      for (int i = 0; i < n; i++) begin
         @(posedge ref_clk) rxd <= bits[i]; // low stop makes framing or break
         repeat (BIT_CLKS - 1) @(posedge ref_clk);
      end
      @(posedge ref_clk) rxd <= 1'b1;
      // two idle bits give the receiver time to store the byte
      repeat (2 * BIT_CLKS) @(posedge ref_clk);
   endtask : send

   // capture one frame mid-bit; ninth bit only when asked for
   task automatic recv(input logic has_ninth, output logic [8:0] got);
      got = 9'h000;
      while (txd_q !== 1'b0) @(posedge ref_clk);
      repeat (BIT_CLKS / 2) @(posedge ref_clk);
      for (int i = 0; i < 9; i++) begin
         if (i < 8 || has_ninth) begin
            repeat (BIT_CLKS) @(posedge ref_clk);
            got[i] = txd_q;
         end
      end
      // wait to mid stop bit so the next call sees a fresh start
      repeat (BIT_CLKS) @(posedge ref_clk);
   endtask : recv
endmodule : urxtx_remote

// File: src/urxtx_pkg.sv
/*
 * urxtx_pkg: register offsets, field positions, reset values, mode codes
 * and carrier types of the serial transmit/receive block.
 * Assumes a 12-bit byte-wide register port; offsets are the printed ones.
 */
package urxtx_pkg;

   // register offsets on the plain register port
   localparam logic [11:0] URXTX_DATA_ADDR  = 12'hF40; // tx write / rx read
   localparam logic [11:0] URXTX_STAT0_ADDR = 12'hF41; // main status
   localparam logic [11:0] URXTX_CTL0_ADDR  = 12'hF42; // line control
   localparam logic [11:0] URXTX_CTL1_ADDR  = 12'hF43; // multiprocessor control
   localparam logic [11:0] URXTX_STAT1_ADDR = 12'hF44; // extended status
   localparam logic [11:0] URXTX_ACMP_ADDR  = 12'hF45; // address compare
   localparam logic [11:0] URXTX_BRH_ADDR   = 12'hF46; // baud divisor high
   localparam logic [11:0] URXTX_BRL_ADDR   = 12'hF47; // baud divisor low

   // reset values
   localparam logic [7:0] URXTX_CTL0_RST = 8'h00;
   localparam logic [7:0] URXTX_CTL1_RST = 8'h00;
   localparam logic [7:0] URXTX_ACMP_RST = 8'h00;
   localparam logic [7:0] URXTX_BRH_RST  = 8'hFF;
   localparam logic [7:0] URXTX_BRL_RST  = 8'hFF;

   // main status bit positions
   localparam int URXTX_ST0_RX_AVAIL = 7;
   localparam int URXTX_ST0_PARITY   = 6;
   localparam int URXTX_ST0_OVERRUN  = 5;
   localparam int URXTX_ST0_FRAMING  = 4;
   localparam int URXTX_ST0_BREAK    = 3;
   localparam int URXTX_ST0_TX_EMPTY = 2;
   localparam int URXTX_ST0_TX_IDLE  = 1;
   localparam int URXTX_ST0_CTS      = 0;
   // extended status bit positions
   localparam int URXTX_ST1_NEW_FRAME = 1;
   localparam int URXTX_ST1_MP_RX     = 0;

   // multiprocessor mode field codes
   localparam logic [1:0] URXTX_MPM_ALL        = 2'h0; // every byte
   localparam logic [1:0] URXTX_MPM_ADDR_ONLY  = 2'h1; // address bytes only
   localparam logic [1:0] URXTX_MPM_MATCH_DATA = 2'h2; // data after own address
   localparam logic [1:0] URXTX_MPM_MATCH_ALL  = 2'h3; // own address and its data

   // timing: sixteen oversample ticks per bit
   localparam logic [3:0] URXTX_OVS_LAST  = 4'hF;
   localparam logic [3:0] URXTX_OVS_MID   = 4'h7;
   localparam logic [3:0] URXTX_TX_BASE   = 4'hA; // start + 8 data + 1 stop
   localparam logic [3:0] URXTX_DATA_BITS = 4'h8;

   typedef struct packed {
      logic transmit_enable;
      logic receive_enable;
      logic clear_to_send_gate;
      logic parity_enable;
      logic parity_odd;
      logic send_break;
      logic two_stop;
      logic loopback;
   } urxtx_ctl0_t;

   typedef struct packed {
      logic [1:0] multiprocessor_mode_field;
      logic       multiprocessor_enable;
      logic       multiprocessor_bit_transmit;
      logic [1:0] spare;
      logic       rx_data_irq_off;
      logic       tx_irq_en;
   } urxtx_ctl1_t;

   typedef struct packed {
      logic        wr;    // write strobe
      logic        rd;    // read strobe
      logic [11:0] addr;  // byte offset
      logic [7:0]  wdata; // write data
   } urxtx_bus_req_t;

   typedef enum logic [1:0] {
      URXTX_RX_IDLE,
      URXTX_RX_START,
      URXTX_RX_BITS,
      URXTX_RX_STOP
   } urxtx_rx_state_t;

endpackage : urxtx_pkg

// File: src/urxtx_top.sv
/*
 * urxtx_top: asynchronous serial transmitter and receiver with its
 * register file, overrun handling and 9-bit multiprocessor signalling.
 * Assumes one 100 MHz clock, an active-low asynchronous reset, a register
 * master on the same clock, and rxd / cts_n coming from pins.
 */
`timescale 1ns/1ps

module urxtx_top
   import urxtx_pkg::*;
(
   input  wire logic           ref_clk,
   input  wire logic           resetn,
   input  wire urxtx_bus_req_t bus_req,
   output logic [7:0]          rd_data_q,
   input  wire logic           rxd,
   input  wire logic           cts_n,
   output logic                txd_q,
   output logic                tx_irq_q,
   output logic                rx_irq_q
);

   // pin synchronisers
   logic rxd_s1_q, rxd_s2_q, cts_s1_q, cts_s2_q;
   // configuration registers
   urxtx_ctl0_t ctl0_q;        // line control
   urxtx_ctl1_t ctl1_q;        // multiprocessor control
   logic [7:0]  acmp_q;        // own address
   logic [15:0] brg_q;         // oversample divisor
   logic [15:0] div_cnt_q;     // divisor count-down
   // transmitter
   logic [7:0]  tdr_q;         // transmit data
   logic        tdre_q;        // transmit data empty
   logic [11:0] tx_sh_q;       // frame shifter, lsb first
   logic [3:0]  tx_left_q;     // bits left in frame
   logic [3:0]  tx_ovs_q;      // tick within bit
   // receiver
   urxtx_rx_state_t rx_state_q;
   logic [3:0]  rx_ovs_q;      // tick within bit
   logic [3:0]  rx_cnt_q;      // bits taken
   logic [8:0]  rx_sh_q;       // incoming bits
   logic        rx_prev_q;     // line a cycle back, for start edges
   logic [7:0]  rdr_q;         // receive data
   logic        rda_q;         // receive data available
   logic        fe_q, pe_q;    // framing / parity with held byte
   logic        ovr_pend_q;    // overrun not yet shown
   logic        brk_pend_q;    // break behind hidden overrun
   logic        ovr_vis_q;     // overrun shown
   logic        brk_vis_q;     // break shown
   logic        new_frame_q;   // first data byte after an address
   logic        frame_pend_q;  // address seen, data byte awaited
   logic        mp_rx_q;       // last multiprocessor bit
   logic        matched_q;     // last address was ours
   logic        irq_ok_q;      // held byte may raise data request

   // register port decode
   wire wr_hit   = bus_req.wr;
   wire rd_dat   = bus_req.rd && (bus_req.addr == URXTX_DATA_ADDR);
   wire wr_dat   = wr_hit && (bus_req.addr == URXTX_DATA_ADDR);
   wire wr_ctl0  = wr_hit && (bus_req.addr == URXTX_CTL0_ADDR);
   wire wr_ctl1  = wr_hit && (bus_req.addr == URXTX_CTL1_ADDR);
   wire wr_acmp  = wr_hit && (bus_req.addr == URXTX_ACMP_ADDR);
   wire wr_brh   = wr_hit && (bus_req.addr == URXTX_BRH_ADDR);
   wire wr_brl   = wr_hit && (bus_req.addr == URXTX_BRL_ADDR);

   // oversample tick; a zero divisor runs at full clock rate
   // a divisor write restarts the count, else the reset divisor stalls it for ages
   wire        brg_wr     = wr_brh || wr_brl;
   wire        tick       = (div_cnt_q == 16'h0000);
   wire [15:0] div_reload = (brg_q == 16'h0000) ? 16'h0000 : brg_q - 16'h0001;
   wire [15:0] div_cnt_d  = brg_wr ? 16'h0000 : tick ? div_reload : div_cnt_q - 16'h0001;

   // mode decode
   wire mp_on    = ctl1_q.multiprocessor_enable;
   wire par_on   = ctl0_q.parity_enable && !mp_on;
   wire extra_on = mp_on || par_on;                              // ninth bit present

   // transmit side
   wire        tx_busy  = (tx_left_q != 4'h0);
   wire        tx_run   = ctl0_q.transmit_enable &&
                          (!ctl0_q.clear_to_send_gate || !cts_s2_q);
   wire        tx_load  = !tx_busy && !tdre_q && tx_run;
   wire        tx_ebit  = mp_on ? ctl1_q.multiprocessor_bit_transmit
                                : (^tdr_q ^ ctl0_q.parity_odd);
   wire [11:0] tx_frame = extra_on ? {2'b11, tx_ebit, tdr_q, 1'b0}
                                   : {3'b111, tdr_q, 1'b0};
   wire [3:0]  tx_len   = URXTX_TX_BASE + {3'h0, extra_on} + {3'h0, ctl0_q.two_stop};
   wire        tx_shift = tx_busy && tick && (tx_ovs_q == URXTX_OVS_LAST);
   wire        txd_d    = !ctl0_q.send_break && (tx_busy ? tx_sh_q[0] : 1'b1);

   // receive side; loopback feeds our own line back in
   wire       rx_line  = ctl0_q.loopback ? txd_q : rxd_s2_q;
   wire [3:0] rx_nbits = URXTX_DATA_BITS + {3'h0, extra_on};
   wire       rx_mid   = tick && (rx_ovs_q == URXTX_OVS_MID);
   wire       rx_fall  = rx_prev_q && !rx_line;  // a line held low by a break never restarts
   wire       rx_end   = tick && (rx_ovs_q == URXTX_OVS_LAST);
   wire       rx_done  = (rx_state_q == URXTX_RX_STOP) && rx_end;
   wire [7:0] rx_byte  = extra_on ? rx_sh_q[7:0] : rx_sh_q[8:1];
   wire       rx_xbit  = extra_on && rx_sh_q[8];
   wire       rx_fe    = !rx_line;
   wire       rx_brk   = !rx_line && (rx_sh_q == 9'h000);
   wire       rx_pe    = par_on && (^rx_byte ^ rx_sh_q[8] ^ ctl0_q.parity_odd);
   wire       rx_addr  = mp_on && rx_xbit;                          // address byte
   wire       rx_match = rx_addr && (rx_byte == acmp_q);

   // data request gating in multiprocessor mode
   logic rx_irq_ok;
   always_comb begin
      rx_irq_ok = 1'b1;
      if (mp_on) begin
         unique case (ctl1_q.multiprocessor_mode_field)
            URXTX_MPM_ALL:        rx_irq_ok = 1'b1;
            URXTX_MPM_ADDR_ONLY:  rx_irq_ok = rx_addr;
            URXTX_MPM_MATCH_DATA: rx_irq_ok = !rx_addr && matched_q;
            URXTX_MPM_MATCH_ALL:  rx_irq_ok = rx_addr ? rx_match : matched_q;
         endcase
      end
   end

   // a read that empties the register makes room in the same cycle
   wire rda_kept   = rda_q && !(rd_dat && !ovr_pend_q);
   wire rx_store   = rx_done && !rda_kept;
   wire rx_overrun = rx_done && rda_kept;

   // status views
   wire [7:0] stat0 = {rda_q, pe_q, ovr_vis_q, fe_q, brk_vis_q,
                       tdre_q, !tx_busy, !cts_s2_q};
   wire [7:0] stat1 = {6'h00, new_frame_q, mp_rx_q};
   wire [7:0] rd_mux =
      (bus_req.addr == URXTX_DATA_ADDR)  ? rdr_q :
      (bus_req.addr == URXTX_STAT0_ADDR) ? stat0 :
      (bus_req.addr == URXTX_CTL0_ADDR)  ? ctl0_q :
      (bus_req.addr == URXTX_CTL1_ADDR)  ? ctl1_q :
      (bus_req.addr == URXTX_STAT1_ADDR) ? stat1 :
      (bus_req.addr == URXTX_ACMP_ADDR)  ? acmp_q :
      (bus_req.addr == URXTX_BRH_ADDR)   ? brg_q[15:8] :
      (bus_req.addr == URXTX_BRL_ADDR)   ? brg_q[7:0] : 8'h00;

   // requests from the status held in flops
   wire rx_irq_d = (rda_q && irq_ok_q && !ctl1_q.rx_data_irq_off)
                   || ovr_vis_q || fe_q || brk_vis_q;
   wire tx_irq_d = ctl1_q.tx_irq_en && ctl0_q.transmit_enable && tdre_q;

   // two-stage pin synchronisers, first stage read only by the second
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         {rxd_s1_q, rxd_s2_q, cts_s1_q, cts_s2_q} <= 4'hF;
      end else begin
         {rxd_s2_q, rxd_s1_q} <= {rxd_s1_q, rxd};
         {cts_s2_q, cts_s1_q} <= {cts_s1_q, cts_n};
      end
   end

   // register file and read port; data stand one cycle only
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         ctl0_q    <= urxtx_ctl0_t'(URXTX_CTL0_RST);
         ctl1_q    <= urxtx_ctl1_t'(URXTX_CTL1_RST);
         acmp_q    <= URXTX_ACMP_RST;
         brg_q     <= {URXTX_BRH_RST, URXTX_BRL_RST};
         div_cnt_q <= 16'h0000;
         rd_data_q <= 8'h00;
      end else begin
         if (wr_ctl0) ctl0_q <= urxtx_ctl0_t'(bus_req.wdata);
         if (wr_ctl1) ctl1_q <= urxtx_ctl1_t'(bus_req.wdata);
         if (wr_acmp) acmp_q <= bus_req.wdata;
         if (wr_brh)  brg_q[15:8] <= bus_req.wdata;
         if (wr_brl)  brg_q[7:0]  <= bus_req.wdata;
         div_cnt_q <= div_cnt_d;
         rd_data_q <= bus_req.rd ? rd_mux : 8'h00;
      end
   end

   // transmitter: holding byte, frame shifter, line driver
   // a frame already started finishes even if clear-to-send drops
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         tdr_q     <= 8'h00;
         tdre_q    <= 1'b1;
         tx_sh_q   <= 12'hFFF;
         tx_left_q <= 4'h0;
         tx_ovs_q  <= 4'h0;
         txd_q     <= 1'b1;
         tx_irq_q  <= 1'b0;
      end else begin
         if (wr_dat) tdr_q <= bus_req.wdata;
         // a fresh write keeps the holder full even while the old byte loads
         if (wr_dat) tdre_q <= 1'b0;
         else if (tx_load) tdre_q <= 1'b1;
         if (tx_load) begin
            tx_sh_q   <= tx_frame;
            tx_left_q <= tx_len;
            tx_ovs_q  <= 4'h0;
         end else if (tx_busy && tick) begin
            tx_ovs_q <= tx_ovs_q + 4'h1;
            if (tx_shift) begin
               tx_sh_q   <= {1'b1, tx_sh_q[11:1]};
               tx_left_q <= tx_left_q - 4'h1;
            end
         end
         txd_q    <= txd_d;
         tx_irq_q <= tx_irq_d;
      end
   end

   // receiver bit engine: mid-bit sampling on the oversample tick
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rx_state_q <= URXTX_RX_IDLE;
         rx_ovs_q   <= 4'h0;
         rx_cnt_q   <= 4'h0;
         rx_sh_q    <= 9'h000;
         rx_prev_q  <= 1'b1;
      end else begin
         rx_prev_q  <= rx_line;
         if (tick) rx_ovs_q <= rx_ovs_q + 4'h1;
         unique case (rx_state_q)
            URXTX_RX_IDLE: if (ctl0_q.receive_enable && rx_fall) begin
               rx_state_q <= URXTX_RX_START;
               rx_ovs_q   <= 4'h0;
               rx_sh_q    <= 9'h000;
            end
            // false start: a glitch shorter than half a bit is dropped
            URXTX_RX_START: if (rx_mid) begin
               rx_state_q <= rx_line ? URXTX_RX_IDLE : URXTX_RX_BITS;
               rx_ovs_q   <= 4'h0;
               rx_cnt_q   <= 4'h0;
            end
            URXTX_RX_BITS: if (rx_end) begin
               rx_sh_q  <= {rx_line, rx_sh_q[8:1]};
               rx_cnt_q <= rx_cnt_q + 4'h1;
               if (rx_cnt_q == rx_nbits - 4'h1) rx_state_q <= URXTX_RX_STOP;
            end
            URXTX_RX_STOP: if (rx_end) rx_state_q <= URXTX_RX_IDLE;
         endcase
      end
   end

   // receive data register and its status; the arriving byte wins over a read
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rdr_q <= 8'h00;
         {rda_q, fe_q, pe_q, ovr_pend_q, brk_pend_q} <= 5'h00;
         {ovr_vis_q, brk_vis_q, new_frame_q, frame_pend_q} <= 4'h0;
         {mp_rx_q, matched_q, irq_ok_q, rx_irq_q} <= 4'h0;
      end else begin
         if (rd_dat) begin
            new_frame_q <= 1'b0;
            mp_rx_q     <= 1'b0;
            if (ovr_pend_q) begin
               ovr_vis_q  <= 1'b1;
               brk_vis_q  <= brk_pend_q;
               ovr_pend_q <= 1'b0;
               brk_pend_q <= 1'b0;
            end else begin
               {rda_q, fe_q, pe_q} <= 3'h0;
               {ovr_vis_q, brk_vis_q} <= 2'h0;
            end
         end
         if (rx_overrun) begin
            ovr_pend_q <= 1'b1;
            brk_pend_q <= brk_pend_q || rx_brk;
         end
         if (rx_store) begin
            rdr_q     <= rx_byte;
            rda_q     <= 1'b1;
            fe_q      <= rx_fe;
            pe_q      <= rx_pe;
            brk_vis_q <= rx_brk;
            mp_rx_q   <= rx_xbit;
            irq_ok_q  <= rx_irq_ok;
            new_frame_q  <= !rx_addr && frame_pend_q;
            frame_pend_q <= rx_addr || (frame_pend_q && !mp_on);
         end
         if (rx_done && rx_addr) matched_q <= rx_match;
         rx_irq_q <= rx_irq_d;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   property p_mp_mark;
      tx_load && mp_on |=> tx_sh_q[9] == $past(ctl1_q.multiprocessor_bit_transmit);
   endproperty
   a_mp_mark: assert property (p_mp_mark) else $error("marker bit wrong");

   property p_auto_load;
      (wr_dat && !tx_busy && tdre_q && tx_run) ##1 tx_run |=> tx_busy;
   endproperty
   a_auto_load: assert property (p_auto_load) else $error("byte not loaded");

   property p_tx_req;
      tdre_q && ctl0_q.transmit_enable && ctl1_q.tx_irq_en |=> tx_irq_q;
   endproperty
   a_tx_req: assert property (p_tx_req) else $error("no transmit request");

   property p_store;
      rx_store |=> rda_q && stat0[URXTX_ST0_RX_AVAIL] && rdr_q == $past(rx_byte);
   endproperty
   a_store: assert property (p_store) else $error("byte not stored");

   property p_no_data_irq;
      ctl1_q.rx_data_irq_off && !ovr_vis_q && !fe_q && !brk_vis_q |=> !rx_irq_q;
   endproperty
   a_no_data_irq: assert property (p_no_data_irq) else $error("data request leaked");

   property p_keep;
      rx_overrun |=> rdr_q == $past(rdr_q) && rda_q;
   endproperty
   a_keep: assert property (p_keep) else $error("held byte overwritten");

   property p_hidden;
      rx_overrun && !ovr_vis_q && !rd_dat |=> !ovr_vis_q;
   endproperty
   a_hidden: assert property (p_hidden) else $error("overrun shown early");

   property p_reveal;
      rd_dat && ovr_pend_q |=> ovr_vis_q && rda_q ##1 rx_irq_q;
   endproperty
   a_reveal: assert property (p_reveal) else $error("overrun not shown");

   property p_clear;
      rd_dat && !ovr_pend_q && !rx_done |=> !ovr_vis_q && !brk_vis_q && !rda_q;
   endproperty
   a_clear: assert property (p_clear) else $error("errors not cleared");

   property p_frame_clr;
      rd_dat && !rx_store |=> !new_frame_q && !mp_rx_q;
   endproperty
   a_frame_clr: assert property (p_frame_clr) else $error("flags kept on read");

   property p_tx_hold;
      !tx_run && !tx_busy |=> !tx_busy;
   endproperty
   a_tx_hold: assert property (p_tx_hold) else $error("sent while held");

   property p_framing;
      rx_store && !rx_line |=> fe_q ##1 rx_irq_q;
   endproperty
   a_framing: assert property (p_framing) else $error("framing not flagged");

endmodule : urxtx_top
